/* rtl/elapsed_timer.sv */
// Millisecond delay timer that advances in whole system cycles.
`timescale 1ns/1ps
`default_nettype none

module elapsed_timer #(
	parameter int LIMIT_W = 17,
	parameter int ACC_W   = 28,
	parameter int STEP_US = 1000
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               reset,
	// Control
	input  wire logic               clear,
	input  wire logic               tick,
	input  wire logic [LIMIT_W-1:0] limit_ms,
	// Status
	output logic                    expired
);

	logic [ACC_W-1:0] elapsed_us;
	logic [ACC_W-1:0] target_us;

	// Elapsed time grows by a full cycle per tick, so a limit that is not
	// a whole number of cycles expires at the following cycle.
	assign target_us = ACC_W'(limit_ms) * ACC_W'(speed_brake_pkg::US_PER_MS);
	assign expired   = (elapsed_us >= target_us);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			elapsed_us <= '0;
		end else if (clear) begin
			elapsed_us <= '0;
		end else if (tick && !expired) begin
			elapsed_us <= elapsed_us + ACC_W'(STEP_US);
		end
	end

endmodule

`default_nettype wire

/* rtl/safe_speed_range_brake_control.sv */
// Speed range monitor with tolerance range, and safe brake output for one axis.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - While monitoring, compare speed with both limits on every system cycle.
// - Limits are signed 25-bit values; defaults are +100000 and -100000.
// - Standard variant: violation requests stop ramp on the axis, acknowledge drops.
// - Monitor-only variant: violation only drops the acknowledge output.
// - Activation pin is active low: 0 enables monitoring, 1 disables it.
// - Acknowledge is 1 within limits, 0 on violation or when inactive.
// - Delays not a whole number of cycles expire at the next cycle.
// - Optional tolerance range, off by default, defers reaction on an overshoot.
// - Tolerance window widens limits by 1 to 25 percent, default 1.
// - Tolerance time bounds overshoot width, 1 to 120000 ms, default 100.
// - Tolerance period bounds oscillation period, 2 to 120000 ms, default 1000.
// - Leaving the tolerance range requests stop ramp and drops acknowledge.
// - Brake function becomes active whenever torque off is active on its axis.
// - Active brake function holds the brake output at 0.
// - Inactive brake function sets the output from its configured parameters.
// - Brake block is bound to axis one or axis two, default axis one.
// - Torque off on the bound axis forces the output off, ignoring requests.
// - Drive controller brake request may be routed onto the safe brake output.
// - Source code 0 no connection, 2 request one, 3 request two.
// - No connection: output 0 under torque off, 1 in run states.
// - Connected: output follows the request in run states, 0 under torque off.
module safe_speed_range_brake_control #(
	parameter int SYS_CYCLE_CLKS = speed_brake_pkg::SYS_CYCLE_CLKS
) (
	// Clock and reset
	input  wire logic                                         clk,
	input  wire logic                                         reset,
	// Configuration
	input  wire speed_brake_pkg::range_cfg_t                  range_cfg,
	input  wire speed_brake_pkg::brake_cfg_t                  brake_cfg,
	// Speed monitoring
	input  wire logic                                         monitor_activation_in_n,
	input  wire logic signed [speed_brake_pkg::SPEED_W-1:0]   actual_speed,
	output logic                                              range_acknowledge_out,
	output logic [1:0]                                        safe_stop_ramp_request,
	// Brake control
	input  wire logic [1:0]                                   torque_off_state,
	input  wire logic [1:0]                                   brake_request,
	output logic                                              safe_brake_out,
	// Status
	output logic                                              monitor_active,
	output logic                                              sys_tick
);

	localparam int TICK_W = $clog2(SYS_CYCLE_CLKS);
	localparam int SW     = speed_brake_pkg::SPEED_W;
	localparam int TW     = speed_brake_pkg::TIME_W;
	localparam int WW     = speed_brake_pkg::WIDE_W;

	typedef enum logic [1:0] {
		ST_IDLE     = 2'h0,
		ST_ON_DELAY = 2'h1,
		ST_WATCH    = 2'h2,
		ST_FAULT    = 2'h3
	} range_state_t;

	range_state_t state;
	range_state_t next_state;

	// ------------------------------------------------------------------
	// Activation pin synchroniser
	// ------------------------------------------------------------------
	logic [2:0] act_sync;
	logic       act_level;
	logic       monitoring_on;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			act_sync <= 3'h7;
		end else begin
			act_sync <= {act_sync[1:0], monitor_activation_in_n};
		end
	end

	// A change is taken only once the last two stages agree.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			act_level <= 1'h1;
		end else if (act_sync[1] == act_sync[2]) begin
			act_level <= act_sync[2];
		end
	end

	assign monitoring_on = !act_level;
	assign monitor_active = monitoring_on;

	// ------------------------------------------------------------------
	// System cycle
	// ------------------------------------------------------------------
	logic [TICK_W-1:0] tick_count;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tick_count <= '0;
			sys_tick   <= 1'h0;
		end else if (tick_count == TICK_W'(SYS_CYCLE_CLKS - 1)) begin
			tick_count <= '0;
			sys_tick   <= 1'h1;
		end else begin
			tick_count <= tick_count + TICK_W'(1);
			sys_tick   <= 1'h0;
		end
	end

	// ------------------------------------------------------------------
	// Configuration clamping
	// ------------------------------------------------------------------
	logic [speed_brake_pkg::PCT_W-1:0] window_pct;
	logic [TW-1:0]                     width_ms;
	logic [TW-1:0]                     period_ms;
	logic [TW-1:0]                     on_delay_ms;

	// Out-of-range settings are pulled to the nearest legal value so a bad
	// setting never yields a zero-width tolerance.
	always_comb begin
		window_pct = range_cfg.tolerance_window_pct;
		if (window_pct < speed_brake_pkg::TOL_WINDOW_MIN) begin
			window_pct = speed_brake_pkg::TOL_WINDOW_MIN;
		end else if (window_pct > speed_brake_pkg::TOL_WINDOW_MAX) begin
			window_pct = speed_brake_pkg::TOL_WINDOW_MAX;
		end
		width_ms = range_cfg.tolerance_width_time;
		if (width_ms < speed_brake_pkg::TOL_TIME_MIN_MS) begin
			width_ms = speed_brake_pkg::TOL_TIME_MIN_MS;
		end else if (width_ms > speed_brake_pkg::TIME_MAX_MS) begin
			width_ms = speed_brake_pkg::TIME_MAX_MS;
		end
		period_ms = range_cfg.tolerance_oscillation_period;
		if (period_ms < speed_brake_pkg::TOL_PERIOD_MIN_MS) begin
			period_ms = speed_brake_pkg::TOL_PERIOD_MIN_MS;
		end else if (period_ms > speed_brake_pkg::TIME_MAX_MS) begin
			period_ms = speed_brake_pkg::TIME_MAX_MS;
		end
		on_delay_ms = range_cfg.on_delay_ms;
		if (on_delay_ms > speed_brake_pkg::TIME_MAX_MS) begin
			on_delay_ms = speed_brake_pkg::TIME_MAX_MS;
		end
	end

	// ------------------------------------------------------------------
	// Limit comparison
	// ------------------------------------------------------------------
	logic              over_nominal;
	logic              over_wide;
	logic [SW-1:0]     upper_mag;
	logic [SW-1:0]     lower_mag;
	logic signed [WW-1:0] speed_x100;
	logic signed [WW-1:0] upper_wide;
	logic signed [WW-1:0] lower_wide;

	// Both limits are full 25-bit signed values, covering the whole range.
	assign over_nominal = (actual_speed > range_cfg.upper_limit) ||
	                      (actual_speed < range_cfg.lower_limit);

	// Scaling by 100 avoids a divider: the percentage is applied to the
	// magnitude of each limit and compared against the scaled speed.
	assign upper_mag  = range_cfg.upper_limit[SW-1] ? SW'(-range_cfg.upper_limit)
	                                                : SW'(range_cfg.upper_limit);
	assign lower_mag  = range_cfg.lower_limit[SW-1] ? SW'(-range_cfg.lower_limit)
	                                                : SW'(range_cfg.lower_limit);
	assign speed_x100 = WW'(actual_speed) * $signed(WW'(speed_brake_pkg::PERCENT_SCALE));
	assign upper_wide = WW'(range_cfg.upper_limit) *
	                    $signed(WW'(speed_brake_pkg::PERCENT_SCALE)) +
	                    $signed(WW'(upper_mag) * WW'(window_pct));
	assign lower_wide = WW'(range_cfg.lower_limit) *
	                    $signed(WW'(speed_brake_pkg::PERCENT_SCALE)) -
	                    $signed(WW'(lower_mag) * WW'(window_pct));
	assign over_wide  = (speed_x100 > upper_wide) || (speed_x100 < lower_wide);

	// ------------------------------------------------------------------
	// Timers
	// ------------------------------------------------------------------
	logic on_delay_done;
	logic width_expired;
	logic period_expired;
	logic overshoot;
	logic overshoot_start;
	logic seen_overshoot;
	logic tolerance_on;

	assign tolerance_on    = range_cfg.tolerance_enable;
	assign overshoot_start = sys_tick && over_nominal && !overshoot && (state == ST_WATCH);

	// The on-delay counts from activation in whole system cycles.
	elapsed_timer #(
		.LIMIT_W (TW),
		.ACC_W   (speed_brake_pkg::ACC_W),
		.STEP_US (speed_brake_pkg::SYS_CYCLE_US)
	) on_delay_timer (
		.clk      (clk),
		.reset    (reset),
		.clear    (state != ST_ON_DELAY),
		.tick     (sys_tick),
		.limit_ms (on_delay_ms),
		.expired  (on_delay_done)
	);

	elapsed_timer #(
		.LIMIT_W (TW),
		.ACC_W   (speed_brake_pkg::ACC_W),
		.STEP_US (speed_brake_pkg::SYS_CYCLE_US)
	) width_timer (
		.clk      (clk),
		.reset    (reset),
		.clear    (!overshoot),
		.tick     (sys_tick),
		.limit_ms (width_ms),
		.expired  (width_expired)
	);

	elapsed_timer #(
		.LIMIT_W (TW),
		.ACC_W   (speed_brake_pkg::ACC_W),
		.STEP_US (speed_brake_pkg::SYS_CYCLE_US)
	) period_timer (
		.clk      (clk),
		.reset    (reset),
		.clear    ((state != ST_WATCH) || overshoot_start),
		.tick     (sys_tick),
		.limit_ms (period_ms),
		.expired  (period_expired)
	);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			overshoot <= 1'h0;
		end else if (state != ST_WATCH) begin
			overshoot <= 1'h0;
		end else if (sys_tick) begin
			overshoot <= over_nominal;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			seen_overshoot <= 1'h0;
		end else if (state != ST_WATCH) begin
			seen_overshoot <= 1'h0;
		end else if (overshoot_start) begin
			seen_overshoot <= 1'h1;
		end
	end

	// ------------------------------------------------------------------
	// Violation decision
	// ------------------------------------------------------------------
	logic violation;

	// With tolerance on, an overshoot is an error only when it leaves the
	// widened window, lasts too long, or repeats within the period.
	always_comb begin
		violation = 1'h0;
		if (sys_tick) begin
			if (!tolerance_on) begin
				violation = over_nominal;
			end else begin
				violation = over_wide ||
				            (overshoot && over_nominal && width_expired) ||
				            (overshoot_start && seen_overshoot && !period_expired);
			end
		end
	end

	// ------------------------------------------------------------------
	// Monitor state machine
	// ------------------------------------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (monitoring_on) begin
					next_state = ST_ON_DELAY;
				end
			end
			ST_ON_DELAY: begin
				if (on_delay_done) begin
					next_state = ST_WATCH;
				end
			end
			ST_WATCH: begin
				if (violation) begin
					next_state = ST_FAULT;
				end
			end
			ST_FAULT: begin
				next_state = ST_FAULT;
			end
		endcase
		if (!monitoring_on) begin
			next_state = ST_IDLE;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------------
	// Monitor outputs
	// ------------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			range_acknowledge_out <= 1'h0;
		end else begin
			range_acknowledge_out <= (state == ST_WATCH) && !violation && monitoring_on;
		end
	end

	// The fault is latched until monitoring is switched off, so the stop
	// ramp is never withdrawn while the drive is still decelerating.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			safe_stop_ramp_request <= 2'h0;
		end else begin
			safe_stop_ramp_request <= 2'h0;
			if ((state == ST_FAULT) && !range_cfg.speed_range_monitor_only) begin
				safe_stop_ramp_request[range_cfg.axis] <= 1'h1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Safe brake output
	// ------------------------------------------------------------------
	logic brake_func_active;

	assign brake_func_active = torque_off_state[brake_cfg.axis];

	// An unused source code engages the brake, the safe side of a bad setting.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			safe_brake_out <= 1'h0;
		end else if (brake_func_active) begin
			safe_brake_out <= 1'h0;
		end else begin
			case (brake_cfg.source)
				speed_brake_pkg::BRAKE_SRC_NONE: safe_brake_out <= 1'h1;
				speed_brake_pkg::BRAKE_SRC_REQ1: safe_brake_out <= brake_request[0];
				speed_brake_pkg::BRAKE_SRC_REQ2: safe_brake_out <= brake_request[1];
				default:                         safe_brake_out <= 1'h0;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	sequence fault_entry;
		##1 (state == ST_FAULT) ##1 !range_acknowledge_out;
	endsequence

	sequence ramp_raised;
		##2 safe_stop_ramp_request[$past(range_cfg.axis, 2)];
	endsequence

	inactive_ack_low_a: assert property (@(posedge clk) disable iff (reset)
		act_level |=> !range_acknowledge_out)
		else $error("acknowledge high while monitoring is off");

	ack_after_delay_a: assert property (@(posedge clk) disable iff (reset)
		$rose(range_acknowledge_out) |-> $past(state) == ST_WATCH)
		else $error("acknowledge raised before on-delay elapsed");

	limit_fault_a: assert property (@(posedge clk) disable iff (reset)
		(state == ST_WATCH) && sys_tick && !tolerance_on && over_nominal && monitoring_on
		|-> fault_entry)
		else $error("limit overshoot did not lead to a fault");

	wide_fault_a: assert property (@(posedge clk) disable iff (reset)
		(state == ST_WATCH) && sys_tick && tolerance_on && over_wide && monitoring_on
		|-> fault_entry)
		else $error("leaving tolerance window did not lead to a fault");

	stop_ramp_a: assert property (@(posedge clk) disable iff (reset)
		(state == ST_WATCH) && violation && monitoring_on &&
		!range_cfg.speed_range_monitor_only ##1
		(monitoring_on && !range_cfg.speed_range_monitor_only && $stable(range_cfg.axis))
		|-> ##1 safe_stop_ramp_request[range_cfg.axis])
		else $error("stop ramp not requested after violation");

	monitor_only_a: assert property (@(posedge clk) disable iff (reset)
		range_cfg.speed_range_monitor_only [*2] |-> safe_stop_ramp_request == 2'h0)
		else $error("monitor-only variant requested a stop ramp");

	tolerated_ack_a: assert property (@(posedge clk) disable iff (reset)
		(state == ST_WATCH) && sys_tick && tolerance_on && over_nominal && !over_wide &&
		!overshoot && !seen_overshoot && monitoring_on |=> range_acknowledge_out)
		else $error("first tolerated overshoot dropped the acknowledge");

	sto_brake_a: assert property (@(posedge clk) disable iff (reset)
		brake_func_active |=> !safe_brake_out)
		else $error("brake released while torque off active");

	no_conn_a: assert property (@(posedge clk) disable iff (reset)
		!brake_func_active && (brake_cfg.source == speed_brake_pkg::BRAKE_SRC_NONE)
		|=> safe_brake_out)
		else $error("unconnected brake output not released in run state");

	follow_req_a: assert property (@(posedge clk) disable iff (reset)
		!brake_func_active && (brake_cfg.source == speed_brake_pkg::BRAKE_SRC_REQ2)
		|=> safe_brake_out == $past(brake_request[1]))
		else $error("brake output does not follow request two");

	ack_fault_a: assert property (@(posedge clk) disable iff (reset)
		(state == ST_FAULT) [*2] |-> !range_acknowledge_out)
		else $error("acknowledge high during latched fault");

endmodule

`default_nettype wire

/* rtl/speed_brake_pkg.sv */
// Shared constants and carrier types for the speed range monitor and safe brake output.
package speed_brake_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 10;
	localparam int SYS_CYCLE_US   = 1000;
	localparam int NS_PER_US      = 1000;
	localparam int US_PER_MS      = 1000;
	localparam int SYS_CYCLE_CLKS = SYS_CYCLE_US * NS_PER_US / CLK_PERIOD_NS;

	// ------------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------------
	localparam int SPEED_W = 25;
	localparam int TIME_W  = 17;
	localparam int PCT_W   = 5;
	localparam int ACC_W   = 28;
	localparam int WIDE_W  = 34;

	// ------------------------------------------------------------------
	// Ranges and values after reset
	// ------------------------------------------------------------------
	localparam logic signed [SPEED_W-1:0] UPPER_LIMIT_DEFAULT = 25'sh00186a0;
	localparam logic signed [SPEED_W-1:0] LOWER_LIMIT_DEFAULT = -25'sh00186a0;
	localparam logic [PCT_W-1:0]  TOL_WINDOW_MIN     = 5'h01;
	localparam logic [PCT_W-1:0]  TOL_WINDOW_MAX     = 5'h19;
	localparam logic [PCT_W-1:0]  TOL_WINDOW_DEFAULT = 5'h01;
	localparam logic [TIME_W-1:0] TIME_MAX_MS        = 17'h1d4c0;
	localparam logic [TIME_W-1:0] TOL_TIME_MIN_MS    = 17'h00001;
	localparam logic [TIME_W-1:0] TOL_TIME_DEFAULT   = 17'h00064;
	localparam logic [TIME_W-1:0] TOL_PERIOD_MIN_MS  = 17'h00002;
	localparam logic [TIME_W-1:0] TOL_PERIOD_DEFAULT = 17'h003e8;
	localparam logic [TIME_W-1:0] ON_DELAY_DEFAULT   = 17'h00014;
	localparam logic [6:0]        PERCENT_SCALE      = 7'h64;

	// ------------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------------
	localparam logic       AXIS_SELECT_FIRST  = 1'h0;
	localparam logic       AXIS_SELECT_SECOND = 1'h1;
	localparam logic [1:0] BRAKE_SRC_NONE     = 2'h0;
	localparam logic [1:0] BRAKE_SRC_REQ1     = 2'h2;
	localparam logic [1:0] BRAKE_SRC_REQ2     = 2'h3;

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic signed [SPEED_W-1:0] upper_limit;
		logic signed [SPEED_W-1:0] lower_limit;
		logic                      tolerance_enable;
		logic [PCT_W-1:0]          tolerance_window_pct;
		logic [TIME_W-1:0]         tolerance_width_time;
		logic [TIME_W-1:0]         tolerance_oscillation_period;
		logic [TIME_W-1:0]         on_delay_ms;
		logic                      speed_range_monitor_only;
		logic                      axis;
	} range_cfg_t;

	typedef struct packed {
		logic       axis;
		logic [1:0] source;
	} brake_cfg_t;

	localparam range_cfg_t RANGE_CFG_DEFAULT = '{
		upper_limit:                  UPPER_LIMIT_DEFAULT,
		lower_limit:                  LOWER_LIMIT_DEFAULT,
		tolerance_enable:             1'h0,
		tolerance_window_pct:         TOL_WINDOW_DEFAULT,
		tolerance_width_time:         TOL_TIME_DEFAULT,
		tolerance_oscillation_period: TOL_PERIOD_DEFAULT,
		on_delay_ms:                  ON_DELAY_DEFAULT,
		speed_range_monitor_only:     1'h0,
		axis:                         AXIS_SELECT_FIRST
	};

	localparam brake_cfg_t BRAKE_CFG_DEFAULT = '{
		axis:   AXIS_SELECT_FIRST,
		source: BRAKE_SRC_NONE
	};

endpackage

/* tb/drive_side_model.sv */
// Behavioural drive controller side: motor speed, torque off state and brake requests.
`timescale 1ns/1ps
`default_nettype none

module drive_side_model (
	// Clock and reset
	input  wire logic                                  clk,
	input  wire logic                                  reset,
	// Commands from the bench
	input  wire logic [speed_brake_pkg::SPEED_W-1:0] cmd_speed,
	input  wire logic [1:0]                          cmd_torque_off,
	input  wire logic [1:0]                          cmd_brake_request,
	// Device side
	input  wire logic [1:0]                          safe_stop_ramp_request,
	output logic [speed_brake_pkg::SPEED_W-1:0]      actual_speed,
	output logic [1:0]                               torque_off_state,
	output logic [1:0]                               brake_request
);
	// ------------------------------------------------------------------
	// Axis state
	// ------------------------------------------------------------------
	// The stop ramp is taken to end at once in torque off, so a stop ramp on the brake's axis engages the brake.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			actual_speed <= '0;
			torque_off_state <= 2'h3;
			brake_request <= 2'h0;
		end else begin
			actual_speed <= cmd_speed;
			torque_off_state <= cmd_torque_off | safe_stop_ramp_request;
			brake_request <= cmd_brake_request;
		end
	end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the speed range monitor and safe brake output.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic                                   clk;
	logic                                   reset;
	speed_brake_pkg::range_cfg_t            range_cfg;
	speed_brake_pkg::range_cfg_t            cfg;
	speed_brake_pkg::brake_cfg_t            brake_cfg;
	logic                                   act_n;
	logic [speed_brake_pkg::SPEED_W-1:0]    cmd_speed;
	logic [speed_brake_pkg::SPEED_W-1:0]    actual_speed;
	logic [1:0]                             cmd_torque_off;
	logic [1:0]                             cmd_brake_request;
	logic [1:0]                             torque_off_state;
	logic [1:0]                             brake_request;
	logic                                   ack;
	logic [1:0]                             ramp;
	logic                                   brake;
	logic                                   exp_brake;
	logic                                   mon;
	logic                                   tick;
	int                                     n_tick;
	int                                     n_mismatch;
	int                                     samples_checked;
	int                                     k;
	int spd [4] = '{32'sh000186a1, -32'sh000186a1, 32'sh000186a1, -32'sh00000004};
	int safe_spd [4] = '{32'sh00000000, 32'sh00000000, 32'sh00000000, -32'sh01000000};
	logic [1:0] exp_ramp [4] = '{2'h1, 2'h2, 2'h0, 2'h1};

	drive_side_model partner_u (.clk(clk), .reset(reset), .cmd_speed(cmd_speed),
		.cmd_torque_off(cmd_torque_off), .cmd_brake_request(cmd_brake_request),
		.safe_stop_ramp_request(ramp), .actual_speed(actual_speed),
		.torque_off_state(torque_off_state), .brake_request(brake_request));

	safe_speed_range_brake_control #(.SYS_CYCLE_CLKS(10)) dut_u (.clk(clk), .reset(reset),
		.range_cfg(range_cfg), .brake_cfg(brake_cfg), .monitor_activation_in_n(act_n),
		.actual_speed(actual_speed), .range_acknowledge_out(ack),
		.safe_stop_ramp_request(ramp), .torque_off_state(torque_off_state),
		.brake_request(brake_request), .safe_brake_out(brake), .monitor_active(mon),
		.sys_tick(tick));

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic print_verdict();
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check2(input logic [1:0] got, input logic [1:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(negedge clk);
	endtask

	// A level that never comes shows up as a failed compare when the limit runs out.
	task automatic wait_ack(input logic val, input int limit);
		for (int i = 0; i < limit && ack !== val; i++) @(negedge clk);
		check2({1'b0, ack}, {1'b0, val});
	endtask

	task automatic set_speed(input int v);
		@(posedge clk);
		cmd_speed <= 25'(v);
	endtask

	task automatic restart(input speed_brake_pkg::range_cfg_t c, input int v);
		@(posedge clk);
		act_n <= 1'b1;
		range_cfg <= c;
		set_speed(v);
		cycles(8);
		check2({ack, mon} | ramp, 2'h0);
		@(posedge clk);
		act_n <= 1'b0;
	endtask

	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		print_verdict();
	end

	initial begin
		reset = 1'b1;
		range_cfg = speed_brake_pkg::RANGE_CFG_DEFAULT;
		brake_cfg = speed_brake_pkg::BRAKE_CFG_DEFAULT;
		act_n = 1'b1;
		cmd_speed = '0;
		cmd_torque_off = 2'h0;
		cmd_brake_request = 2'h0;
		n_mismatch = 0;
		samples_checked = 0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		cycles(3);
		check2({ack, brake} | ramp, 2'h1);
		@(posedge clk);
		act_n <= 1'b0;
		n_tick = 0;
		repeat (30) begin
			@(negedge clk);
			n_tick += tick;
		end
		cycles(120);
		check2({mon, ack}, 2'h2);
		check2(2'(n_tick), 2'h3);
		wait_ack(1'b1, 120);
		set_speed(32'sh000186a0);
		cycles(25);
		check2({1'b0, ack}, 2'h1);
		for (k = 0; k < 4; k++) begin
			cfg = speed_brake_pkg::RANGE_CFG_DEFAULT;
			cfg.on_delay_ms = 17'h00000;
			cfg.axis = (k == 1);
			cfg.speed_range_monitor_only = (k == 2);
			if (k == 3) begin
				cfg.upper_limit = -25'sh0000005;
				cfg.lower_limit = -25'sh1000000;
			end
			restart(cfg, safe_spd[k]);
			wait_ack(1'b1, 40);
			set_speed(spd[k]);
			wait_ack(1'b0, 15);
			cycles(2);
			check2(ramp, exp_ramp[k]);
			cycles(3);
			check2({1'b0, brake}, {1'b0, ~exp_ramp[k][0]});
		end
		cfg = speed_brake_pkg::RANGE_CFG_DEFAULT;
		cfg.on_delay_ms = 17'h00000;
		cfg.tolerance_enable = 1'b1;
		cfg.tolerance_width_time = 17'h00005;
		restart(cfg, 32'sh00000000);
		wait_ack(1'b1, 40);
		set_speed(32'sh00018894);
		cycles(30);
		check2({ack, 1'b0} | ramp, 2'h2);
		wait_ack(1'b0, 60);
		cycles(2);
		check2(ramp, 2'h1);
		restart(cfg, 32'sh00000000);
		wait_ack(1'b1, 40);
		set_speed(32'sh00018a89);
		wait_ack(1'b0, 15);
		// A second short overshoot inside the tolerance period is an error.
		restart(cfg, 32'sh00000000);
		wait_ack(1'b1, 40);
		set_speed(32'sh00018894);
		cycles(25);
		set_speed(32'sh00000000);
		cycles(25);
		check2({ack, 1'b0} | ramp, 2'h2);
		set_speed(32'sh00018894);
		wait_ack(1'b0, 25);
		@(posedge clk);
		act_n <= 1'b1;
		// The latched stop ramp keeps torque off until deactivation has settled.
		cycles(8);
		// Every axis, source code, torque off pattern and request pattern in turn.
		for (k = 0; k < 128; k++) begin
			@(posedge clk);
			brake_cfg <= '{axis: k[6], source: k[5:4]};
			cmd_torque_off <= k[3:2];
			cmd_brake_request <= k[1:0];
			cycles(4);
			case (k[5:4])
				2'h0: exp_brake = 1'b1;
				2'h2: exp_brake = k[0];
				2'h3: exp_brake = k[1];
				default: exp_brake = 1'b0;
			endcase
			if (k[2 + k[6]]) begin
				exp_brake = 1'b0;
			end
			check2({1'b0, brake}, {1'b0, exp_brake});
		end
		print_verdict();
	end
endmodule
`default_nettype wire
